// ### rtl/aao_regs.svh
// Register offsets, field positions, opcodes and reset values of the add/AND datapath
// How it works
// - Immediate add: accumulator plus byte into accumulator, carry, nibble and zero.
// - Register add: accumulator plus file byte, carry, nibble and zero updated.
// - Destination bit 0 writes accumulator, 1 writes file byte; other untouched.
// - Immediate AND: accumulator AND byte into accumulator, only zero updated and bad-op cleared.
// - Register AND: accumulator AND file byte, only zero updated and bad-op cleared.
// - File addresses 00h..7Fh, immediates 00h..FFh, destination bit 0 or 1.
`ifndef AAO_REGS_SVH
`define AAO_REGS_SVH

// ==========================================================================
// Register byte offsets
`define AAO_OFS_INSTR    8'h00
`define AAO_OFS_ACC      8'h04
`define AAO_OFS_STATUS   8'h08
`define AAO_OFS_FADDR    8'h0c
`define AAO_OFS_FDATA    8'h10

// ==========================================================================
// Status bit positions
`define AAO_ST_CARRY     0
`define AAO_ST_NIBBLE    1
`define AAO_ST_ZERO      2
`define AAO_ST_BADOP     3

// ==========================================================================
// Instruction word fields and opcode classes
`define AAO_INSTR_W      14
`define AAO_OPC_HI       13
`define AAO_OPC_LO       8
`define AAO_DEST_BIT     7
`define AAO_FADDR_W      7
`define AAO_OPC_ADD_IMM  6'h1c
`define AAO_OPC_AND_IMM  6'h1b
`define AAO_OPC_ADD_REG  6'h07
`define AAO_OPC_AND_REG  6'h05

// ==========================================================================
// Reset values
`define AAO_RST_ACC      8'h00
`define AAO_RST_FLAGS    4'h0
`define AAO_RST_FADDR    7'h00
`define AAO_RST_INSTR    14'h0000
`define AAO_RST_PRDATA   32'h0000_0000

`endif

// ### rtl/aao_pkg.sv
// Types and shared arithmetic of the add/AND datapath
`include "aao_regs.svh"

package aao_pkg;

   // ==========================================================================
   // Decoded operation, bus state and carriers
   typedef enum logic [2:0] {OP_NONE, OP_ADD_IMM, OP_AND_IMM, OP_ADD_REG, OP_AND_REG} aao_op_t;

   typedef enum logic [1:0] {ST_IDLE, ST_WORK, ST_DONE} aao_state_t;

   // Bit order matches the status register layout
   typedef struct packed {
      logic bad_op;
      logic zero;
      logic nibble;
      logic carry;
   } aao_flags_t;

   typedef struct packed {
      logic [7:0] value;
      aao_flags_t flags;
      logic       acc_we;
      logic       mem_we;
   } aao_result_t;

   // ==========================================================================
   // Opcode class decode
   function automatic aao_op_t aao_decode(input logic [`AAO_INSTR_W-1:0] instr);
      aao_op_t op;
      op = OP_NONE;
      unique case (instr[`AAO_OPC_HI:`AAO_OPC_LO])
         `AAO_OPC_ADD_IMM: op = OP_ADD_IMM;
         `AAO_OPC_AND_IMM: op = OP_AND_IMM;
         `AAO_OPC_ADD_REG: op = OP_ADD_REG;
         `AAO_OPC_AND_REG: op = OP_AND_REG;
         default:          op = OP_NONE;
      endcase
      return op;
   endfunction

   // ==========================================================================
   // One instruction: result value, flags and where it goes
   function automatic aao_result_t aao_exec(input aao_op_t    op,
                                            input logic [7:0] acc,
                                            input logic [7:0] operand,
                                            input logic       dest,
                                            input aao_flags_t flags);
      aao_result_t r;
      logic [8:0]  sum;
      logic [4:0]  low;
      sum     = {1'b0, acc} + {1'b0, operand};
      low     = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
      r.value = 8'h00;
      r.flags = flags;
      r.acc_we = 1'b0;
      r.mem_we = 1'b0;
      r.flags.bad_op = 1'b0;
      unique case (op)
         OP_ADD_IMM, OP_ADD_REG: begin
            r.value        = sum[7:0];
            r.flags.carry  = sum[8];
            r.flags.nibble = low[4];
         end
         OP_AND_IMM, OP_AND_REG: begin
            r.value = acc & operand;
         end
         OP_NONE: begin
            r.flags.bad_op = 1'b1;
         end
      endcase
      if (op != OP_NONE) begin
         r.flags.zero = (r.value == 8'h00);
      end
      // Immediate forms always land in the accumulator
      r.acc_we = (op == OP_ADD_IMM) || (op == OP_AND_IMM) ||
                 (((op == OP_ADD_REG) || (op == OP_AND_REG)) && !dest);
      r.mem_we = ((op == OP_ADD_REG) || (op == OP_AND_REG)) && dest;
      return r;
   endfunction

endpackage

// ### rtl/aao_file_mem.sv
// Register file of 128 bytes with registered read data
`timescale 1ns/100ps
`include "aao_regs.svh"

module aao_file_mem
   import aao_pkg::*;
(
   input  wire logic                    ref_clk,  // Core clock
   input  wire logic                    we,       // Write strobe
   input  wire logic [`AAO_FADDR_W-1:0] waddr,    // Write address
   input  wire logic [7:0]              wdata,    // Write byte
   input  wire logic                    re,       // Read strobe
   input  wire logic [`AAO_FADDR_W-1:0] raddr,    // Read address
   output logic      [7:0]              rdata     // Read byte, held between reads
);

   logic [7:0] mem_q [0:(1<<`AAO_FADDR_W)-1];
   logic [7:0] rdata_d;

   // ==========================================================================
   // Next read data; holds when no read so the operand stays stable
   always_comb begin
      rdata_d = rdata;
      if (re) begin
         rdata_d = mem_q[raddr];
      end
   end

   // No reset on the array: contents are undefined until software writes them
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
      rdata <= rdata_d;
   end

endmodule

// ### rtl/aao_core.sv
// Add/AND execution datapath with APB register access
`timescale 1ns/100ps
`include "aao_regs.svh"

module aao_core
   import aao_pkg::*;
(
   input  wire logic        ref_clk,  // Core clock, 125 MHz
   input  wire logic        rst,      // Synchronous reset, active high
   input  wire logic        psel,     // APB select
   input  wire logic        penable,  // APB access phase
   input  wire logic        pwrite,   // APB direction, high for write
   input  wire logic [7:0]  paddr,    // APB byte address
   input  wire logic [31:0] pwdata,   // APB write data
   output logic      [31:0] prdata,   // APB read data, registered
   output logic             pready,   // APB ready
   output logic             pslverr   // APB error on unmapped address
);

   // ==========================================================================
   // State
   aao_state_t                state_q, state_d;
   logic [7:0]                acc_q, acc_d;
   aao_flags_t                flags_q, flags_d;
   logic [`AAO_FADDR_W-1:0]   faddr_q, faddr_d;
   logic [`AAO_INSTR_W-1:0]   instr_q, instr_d;
   logic [31:0]               prdata_q, prdata_d;

   // ==========================================================================
   // Datapath wires
   logic                      access;
   logic                      mapped;
   logic                      is_instr;
   logic [`AAO_INSTR_W-1:0]   new_instr;
   aao_op_t                   op;
   logic [7:0]                operand;
   logic [7:0]                mem_rdata;
   aao_result_t               res;
   logic                      mem_re;
   logic [`AAO_FADDR_W-1:0]   mem_raddr;
   logic                      mem_we;
   logic [`AAO_FADDR_W-1:0]   mem_waddr;
   logic [7:0]                mem_wdata;

   // ==========================================================================
   // Address decode, shared by the error answer and the commit
   function automatic logic aao_is_mapped(input logic [7:0] a);
      return (a == `AAO_OFS_INSTR) || (a == `AAO_OFS_ACC) || (a == `AAO_OFS_STATUS) ||
             (a == `AAO_OFS_FADDR) || (a == `AAO_OFS_FDATA);
   endfunction

   assign access    = psel && penable;
   assign mapped    = aao_is_mapped(paddr);
   assign is_instr  = (paddr == `AAO_OFS_INSTR);
   assign new_instr = pwdata[`AAO_INSTR_W-1:0];

   // ==========================================================================
   // Instruction decode and execution
   // Only the low 14 bits count; upper write data bits are ignored
   assign op = aao_decode(new_instr);
   // Immediate takes the full byte, file form takes the byte fetched at the low 7 bits
   assign operand = ((op == OP_ADD_IMM) || (op == OP_AND_IMM)) ?
                    new_instr[7:0] : mem_rdata;
   assign res = aao_exec(op, acc_q, operand, new_instr[`AAO_DEST_BIT], flags_q);

   // ==========================================================================
   // File fetch: issued in the first access cycle so the byte is ready for the commit
   assign mem_re    = (state_q == ST_IDLE) && access;
   assign mem_raddr = is_instr ? new_instr[`AAO_FADDR_W-1:0] : faddr_q;

   // ==========================================================================
   // Bus handshake: two wait states on every access
   assign pready  = (state_q == ST_DONE);
   assign pslverr = (state_q == ST_DONE) && !mapped;
   assign prdata  = prdata_q;

   // ==========================================================================
   // Next state of the bus sequencer and the architectural registers
   always_comb begin
      state_d   = state_q;
      acc_d     = acc_q;
      flags_d   = flags_q;
      faddr_d   = faddr_q;
      instr_d   = instr_q;
      prdata_d  = prdata_q;
      mem_we    = 1'b0;
      mem_waddr = faddr_q;
      mem_wdata = pwdata[7:0];
      unique case (state_q)
         ST_IDLE: begin
            if (access) begin
               state_d = ST_WORK;
            end
         end
         ST_WORK: begin
            // Read data is captured a cycle early so it leaves a flip-flop
            prdata_d = 32'h0000_0000;
            if (!pwrite) begin
               unique case (paddr)
                  `AAO_OFS_INSTR:  prdata_d = {18'h0_0000, instr_q};
                  `AAO_OFS_ACC:    prdata_d = {24'h00_0000, acc_q};
                  `AAO_OFS_STATUS: prdata_d = {28'h000_0000, flags_q};
                  `AAO_OFS_FADDR:  prdata_d = {25'h000_0000, faddr_q};
                  `AAO_OFS_FDATA:  prdata_d = {24'h00_0000, mem_rdata};
                  default:         prdata_d = 32'h0000_0000;
               endcase
            end
            state_d = ST_DONE;
         end
         ST_DONE: begin
            state_d = ST_IDLE;
            // Writes take effect only at the ready edge
            if (pwrite && mapped) begin
               unique case (paddr)
                  `AAO_OFS_INSTR: begin
                     instr_d = new_instr;
                     flags_d = res.flags;
                     if (res.acc_we) begin
                        acc_d = res.value;
                     end
                     if (res.mem_we) begin
                        mem_we    = 1'b1;
                        mem_waddr = new_instr[`AAO_FADDR_W-1:0];
                        mem_wdata = res.value;
                     end
                  end
                  `AAO_OFS_ACC:    acc_d   = pwdata[7:0];
                  `AAO_OFS_STATUS: flags_d = pwdata[3:0];
                  `AAO_OFS_FADDR:  faddr_d = pwdata[`AAO_FADDR_W-1:0];
                  `AAO_OFS_FDATA:  mem_we  = 1'b1;
                  default:         mem_we  = 1'b0;
               endcase
            end
         end
      endcase
   end

   // ==========================================================================
   // Registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q  <= ST_IDLE;
         acc_q    <= `AAO_RST_ACC;
         flags_q  <= `AAO_RST_FLAGS;
         faddr_q  <= `AAO_RST_FADDR;
         instr_q  <= `AAO_RST_INSTR;
         prdata_q <= `AAO_RST_PRDATA;
      end else begin
         state_q  <= state_d;
         acc_q    <= acc_d;
         flags_q  <= flags_d;
         faddr_q  <= faddr_d;
         instr_q  <= instr_d;
         prdata_q <= prdata_d;
      end
   end

   // ==========================================================================
   // Register file
   aao_file_mem u_file (
      .ref_clk (ref_clk),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (mem_wdata),
      .re      (mem_re),
      .raddr   (mem_raddr),
      .rdata   (mem_rdata)
   );

endmodule

// ### dv/aao_core_sva.sv
// Port checker for the add/AND datapath register interface
`timescale 1ns/100ps
`include "aao_regs.svh"

module aao_core_sva
   import aao_pkg::*;
(
   input wire logic        ref_clk,  // Core clock
   input wire logic        rst,      // Synchronous reset
   input wire logic        psel,     // Select
   input wire logic        penable,  // Access phase
   input wire logic        pwrite,   // Direction
   input wire logic [7:0]  paddr,    // Byte address
   input wire logic [31:0] pwdata,   // Write data
   input wire logic [31:0] prdata,   // Read data
   input wire logic        pready,   // Ready
   input wire logic        pslverr   // Error
);
   // ==========================================================================
   // Address decode, only five aligned words exist
   logic mapped;
   logic rd_ok;
   assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
   assign rd_ok  = pready && !pwrite;

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_ready_waits: assert property ($rose(penable) && psel |-> !pready ##1 !pready ##1 pready)
      else $error("ready not on third access cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_unmapped: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped access not refused");
   a_err_only_bad: assert property (pslverr |-> pready && !mapped)
      else $error("error on mapped access");
   a_acc_byte_wide: assert property (rd_ok && paddr == `AAO_OFS_ACC |-> prdata[31:8] == 24'h0)
      else $error("accumulator read wider than a byte");
   a_status_width: assert property (rd_ok && paddr == `AAO_OFS_STATUS |-> prdata[31:4] == 28'h0)
      else $error("status read has stray bits");
   a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returns data");

   // Main scenarios reached
   c_instr_write: cover property (pready && pwrite && paddr == `AAO_OFS_INSTR);
   c_refused: cover property (pslverr);
   c_status_read: cover property (rd_ok && paddr == `AAO_OFS_STATUS);
endmodule

bind aao_core aao_core_sva u_sva (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));

// ### dv/test_add_and_alu_ops.sv
// Self-checking bench for the add/AND datapath
`timescale 1ns/100ps
`include "aao_regs.svh"

module test_add_and_alu_ops
   import aao_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rdv;
   logic        erv;
   int          bad_count   = 0;
   int          checks_done = 0;

   aao_core DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // Clock, 8 ns period
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end

   // ==========================================================================
   // Tasks
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // One bus transfer; request held until ready is sampled high
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         close_out();
      end else begin
         rdv = prdata;
         erv = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      check(rdv, exp);
   endtask

   // Load operands, run one instruction, compare every affected location
   task automatic run_op(input logic [5:0] opc, input logic [7:0] a, input logic [7:0] b,
                         input logic d, input logic [6:0] fa, input logic [3:0] pre);
      logic [8:0]  sum;
      logic [4:0]  low;
      logic [7:0]  res;
      logic [3:0]  st;
      logic        regf;
      logic        add;
      logic [13:0] word;
      regf = (opc == `AAO_OPC_ADD_REG) || (opc == `AAO_OPC_AND_REG);
      add  = (opc == `AAO_OPC_ADD_REG) || (opc == `AAO_OPC_ADD_IMM);
      sum  = {1'b0, a} + {1'b0, b};
      low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      res  = add ? sum[7:0] : (a & b);
      if (add) st = {1'b0, res == 8'h00, low[4], sum[8]};
      else if (regf || opc == `AAO_OPC_AND_IMM) st = {1'b0, res == 8'h00, pre[1:0]};
      else st = {1'b1, pre[2:0]};
      word = regf ? {opc, d, fa} : {opc, b};
      xfer(`AAO_OFS_ACC, 1'b1, {24'h0, a});
      xfer(`AAO_OFS_STATUS, 1'b1, {28'h0, pre});
      if (regf) begin
         xfer(`AAO_OFS_FADDR, 1'b1, {25'h0, fa});
         xfer(`AAO_OFS_FDATA, 1'b1, {24'h0, b});
      end
      xfer(`AAO_OFS_INSTR, 1'b1, {18'h0, word});
      rd_chk(`AAO_OFS_ACC, {24'h0, (regf && d) || st[3] ? a : res});
      rd_chk(`AAO_OFS_STATUS, {28'h0, st});
      if (regf) rd_chk(`AAO_OFS_FDATA, {24'h0, d ? res : b});
      rd_chk(`AAO_OFS_INSTR, {18'h0, word});
   endtask

   // ==========================================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk(`AAO_OFS_ACC, 32'h0);
      rd_chk(`AAO_OFS_STATUS, 32'h0);
      rd_chk(`AAO_OFS_INSTR, 32'h0);
      // Unmapped read: error flag and zero data compared apart, each a full word
      xfer(8'h14, 1'b0, 32'h0);
      check({31'h0, erv}, 32'h1);
      check(rdv, 32'h0);
      xfer(8'h06, 1'b1, 32'hffff_ffff);
      check({31'h0, erv}, 32'h1);
      xfer(`AAO_OFS_FADDR, 1'b1, 32'hffff_ffff);
      rd_chk(`AAO_OFS_FADDR, 32'h7f);
      run_op(`AAO_OPC_ADD_IMM, 8'h10, 8'h15, 1'b0, 7'h00, 4'h0);
      run_op(`AAO_OPC_ADD_IMM, 8'hff, 8'h01, 1'b0, 7'h00, 4'h0);
      run_op(`AAO_OPC_ADD_IMM, 8'h08, 8'h08, 1'b0, 7'h00, 4'h7);
      run_op(`AAO_OPC_ADD_REG, 8'h17, 8'hc2, 1'b0, 7'h7f, 4'h7);
      run_op(`AAO_OPC_ADD_REG, 8'hf0, 8'h20, 1'b1, 7'h00, 4'h4);
      run_op(`AAO_OPC_AND_IMM, 8'ha3, 8'h5f, 1'b0, 7'h00, 4'h3);
      run_op(`AAO_OPC_AND_IMM, 8'h0f, 8'hf0, 1'b0, 7'h00, 4'h0);
      run_op(`AAO_OPC_AND_REG, 8'h17, 8'hc2, 1'b1, 7'h40, 4'h1);
      run_op(`AAO_OPC_AND_REG, 8'h55, 8'haa, 1'b0, 7'h7f, 4'h2);
      run_op(6'h1d, 8'h33, 8'h44, 1'b0, 7'h00, 4'h5);
      // Mid-run reset with live state: architectural registers must clear again
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk(`AAO_OFS_ACC, 32'h0);
      rd_chk(`AAO_OFS_STATUS, 32'h0);
      rd_chk(`AAO_OFS_FADDR, 32'h0);
      close_out();
   end
endmodule
